/* File: core/cmsd_map.vh */
// Address map, field positions and reset values of the memory space decoder
`ifndef CMSD_MAP_VH
`define CMSD_MAP_VH
`define CMSD_PROG_LAST 16'h807F
`define CMSD_PROG_BYTES 32896
`define CMSD_RSVD_FIRST 16'h7E00
`define CMSD_RSVD_LAST 16'h7FFF
`define CMSD_PER_BASE 8'h80
`define CMSD_STP_ADDR 8'h81
`define CMSD_PSC_ADDR 8'h8F
`define CMSD_STAT_ADDR 8'hD0
`define CMSD_STP_RESET 8'h07
`define CMSD_STAT_RESET 8'h00
`define CMSD_PSC_RESET 8'h00
`define CMSD_PSC_WEN_BIT 0
`define CMSD_BANK_LO_BIT 3
`define CMSD_BANK_HI_BIT 4
`define CMSD_BITRAM_BASE 8'h20
`define CMSD_REC_BITS 32
`endif

/* File: core/cmsd_stack_record.v */
// Stack record shift register with overflow and underflow detection
`timescale 1ns/100ps
`include "cmsd_map.vh"
module cmsd_stack_record #(
  parameter DEPTH = `CMSD_REC_BITS
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire push1_i,
  input wire push2_i,
  input wire pop1_i,
  input wire pop2_i,
  output reg overflow_o,
  output reg underflow_o,
  output reg [6:0] fill_o
);
  reg [DEPTH-1:0] rec;
  reg [6:0] next_fill;
  always @* begin
    next_fill = fill_o;
    if (push1_i)
      next_fill = fill_o + 7'd1;
    else if (push2_i)
      next_fill = fill_o + 7'd2;
    else if (pop1_i)
      next_fill = fill_o - 7'd1;
    else if (pop2_i)
      next_fill = fill_o - 7'd2;
  end
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rec <= {DEPTH{1'b0}};
      fill_o <= 7'd0;
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
      if (push1_i) begin
        rec <= {rec[DEPTH-2:0], 1'b1};
        if (fill_o >= DEPTH) overflow_o <= 1'b1;
        else fill_o <= next_fill;
      end else if (push2_i) begin
        rec <= {rec[DEPTH-3:0], 2'b11};
        if (fill_o + 7'd2 > DEPTH) overflow_o <= 1'b1;
        else fill_o <= next_fill;
      end else if (pop1_i) begin
        rec <= {1'b0, rec[DEPTH-1:1]};
        if (fill_o < 7'd1) underflow_o <= 1'b1;
        else fill_o <= next_fill;
      end else if (pop2_i) begin
        rec <= {2'b00, rec[DEPTH-1:2]};
        if (fill_o < 7'd2) underflow_o <= 1'b1;
        else fill_o <= next_fill;
      end
    end
  end
endmodule

/* File: core/cmsd_core.v */
// Memory space decoder: program store, data RAM, banks, bits, stack
`timescale 1ns/100ps
`include "cmsd_map.vh"
module cmsd_core #(
  parameter PROG_BYTES = `CMSD_PROG_BYTES
) (
  input wire clk_i,
  input wire rst_n_i,
  // Data access request; mode 0 direct, 1 indirect, 2 register, 3 @Ri
  input wire acc_en_i,
  input wire acc_wr_i,
  input wire acc_bit_i,
  input wire [1:0] acc_mode_i,
  input wire [7:0] acc_addr_i,
  input wire [7:0] acc_wdata_i,
  input wire acc_bit_wdata_i,
  output reg [7:0] acc_rdata_o,
  output reg acc_bit_rdata_o,
  output reg acc_valid_o,
  // Peripheral register side
  output reg per_en_o,
  output reg per_wr_o,
  output reg [7:0] per_addr_o,
  output reg [7:0] per_wdata_o,
  input wire [7:0] per_rdata_i,
  // Stack operations
  input wire push_i,
  input wire pop_i,
  input wire [7:0] push_data_i,
  input wire call_i,
  input wire ret_i,
  output reg [7:0] pop_data_o,
  output reg [7:0] stack_top_pointer_o,
  output reg stack_overflow_o,
  output reg stack_underflow_o,
  // Program store and active register bank
  input wire prog_en_i,
  input wire prog_wr_i,
  input wire [15:0] prog_addr_i,
  input wire [7:0] prog_wdata_i,
  output reg [7:0] prog_rdata_o,
  output reg prog_valid_o,
  output reg prog_wr_refused_o,
  output reg [1:0] active_bank_o
);
  localparam MODE_DIRECT = 2'd0;
  localparam MODE_INDIRECT = 2'd1;
  localparam MODE_REG = 2'd2;
  localparam MODE_PTR = 2'd3;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] prog_mem [0:PROG_BYTES-1];
  reg [7:0] data_ram [0:255];
  reg [7:0] stack_top_pointer;
  reg [7:0] processor_status_word;
  reg [7:0] program_store_control;
  wire [1:0] bank;
  wire [1:0] next_bank;
  reg [7:0] next_stp;
  reg [7:0] next_psw;
  reg [7:0] next_psc;
  wire rec_ovf;
  wire rec_unf;
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function [7:0] bit_byte;
    input [7:0] ba;
    begin
      if (ba[7])
        bit_byte = {ba[7:3], 3'b000};
      else
        bit_byte = `CMSD_BITRAM_BASE + {4'h0, ba[6:3]};
    end
  endfunction
  function [7:0] reg_addr;
    input [1:0] bk;
    input [2:0] rn;
    begin
      reg_addr = {3'b000, bk, rn};
    end
  endfunction
  function is_local;
    input [7:0] ad;
    begin
      is_local = (ad == `CMSD_STP_ADDR) || (ad == `CMSD_STAT_ADDR) ||
                 (ad == `CMSD_PSC_ADDR);
    end
  endfunction
  assign bank = {processor_status_word[`CMSD_BANK_HI_BIT],
                 processor_status_word[`CMSD_BANK_LO_BIT]};
  // Bank seen by the access after a status write
  assign next_bank = {next_psw[`CMSD_BANK_HI_BIT],
                      next_psw[`CMSD_BANK_LO_BIT]};
  wire [7:0] ptr_slot = reg_addr(bank, {2'b00, acc_addr_i[0]});
  // ----------------------------------------
  // Address resolution
  // ----------------------------------------
  reg [7:0] eff_addr;
  reg to_per;
  reg [7:0] cur_byte;
  reg [7:0] new_byte;
  always @* begin
    eff_addr = acc_addr_i;
    to_per = 1'b0;
    case (acc_mode_i)
      MODE_DIRECT: begin
        if (acc_bit_i)
          eff_addr = bit_byte(acc_addr_i);
        to_per = eff_addr[7];
      end
      MODE_INDIRECT: begin
        eff_addr = acc_addr_i;
        to_per = 1'b0;
      end
      MODE_REG: begin
        eff_addr = reg_addr(bank, acc_addr_i[2:0]);
      end
      MODE_PTR: begin
        // Pointer held in R0/R1 of the active bank
        eff_addr = data_ram[ptr_slot];
      end
      default: begin
        eff_addr = acc_addr_i;
      end
    endcase
    if (eff_addr == `CMSD_STP_ADDR && to_per)
      cur_byte = stack_top_pointer;
    else if (eff_addr == `CMSD_STAT_ADDR && to_per)
      cur_byte = processor_status_word;
    else if (eff_addr == `CMSD_PSC_ADDR && to_per)
      cur_byte = program_store_control;
    else if (to_per)
      cur_byte = per_rdata_i;
    else
      cur_byte = data_ram[eff_addr];
    new_byte = cur_byte;
    if (acc_bit_i)
      new_byte[acc_addr_i[2:0]] = acc_bit_wdata_i;
    else
      new_byte = acc_wdata_i;
  end
  wire local_reg = to_per && is_local(eff_addr);
  wire [7:0] push_addr = stack_top_pointer + 8'h01;
  wire [7:0] pop_addr = stack_top_pointer - 8'h01;
  wire data_wr = acc_en_i && acc_wr_i;
  wire local_wr = data_wr && to_per;
  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  // Push wins over pop, pop over a pointer write
  always @* begin
    next_stp = stack_top_pointer;
    if (push_i)
      next_stp = push_addr;
    else if (pop_i)
      next_stp = pop_addr;
    else if (local_wr && eff_addr == `CMSD_STP_ADDR)
      next_stp = new_byte;
  end
  always @* begin
    next_psw = processor_status_word;
    if (local_wr && eff_addr == `CMSD_STAT_ADDR)
      next_psw = new_byte;
  end
  always @* begin
    next_psc = program_store_control;
    if (local_wr && eff_addr == `CMSD_PSC_ADDR)
      next_psc = new_byte;
  end
  // ----------------------------------------
  // Local registers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      stack_top_pointer <= `CMSD_STP_RESET;
    end else begin
      stack_top_pointer <= next_stp;
    end
  end
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      processor_status_word <= `CMSD_STAT_RESET;
    end else begin
      processor_status_word <= next_psw;
    end
  end
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      program_store_control <= `CMSD_PSC_RESET;
    end else begin
      program_store_control <= next_psc;
    end
  end
  // ----------------------------------------
  // Data RAM write port
  // ----------------------------------------
  reg ram_we;
  reg [7:0] ram_wa;
  reg [7:0] ram_wd;
  // One write port; a push takes it first
  always @* begin
    ram_we = 1'b0;
    ram_wa = eff_addr;
    ram_wd = new_byte;
    if (push_i) begin
      ram_we = 1'b1;
      ram_wa = push_addr;
      ram_wd = push_data_i;
    end else if (data_wr && !to_per) begin
      ram_we = 1'b1;
    end
  end
  always @(posedge clk_i) begin
    if (ram_we)
      data_ram[ram_wa] <= ram_wd;
  end
  // ----------------------------------------
  // Program store
  // ----------------------------------------
  wire prog_hit = prog_addr_i <= `CMSD_PROG_LAST;
  wire prog_wen = program_store_control[`CMSD_PSC_WEN_BIT];
  wire prog_rd = prog_en_i && !prog_wr_i;
  wire prog_wr = prog_en_i && prog_wr_i;
  wire prog_wr_ok = prog_wr && prog_wen && prog_hit;
  always @(posedge clk_i) begin
    if (prog_wr_ok)
      prog_mem[prog_addr_i] <= prog_wdata_i;
  end
  // Refused writes leave the store untouched
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_valid_o <= 1'b0;
      prog_wr_refused_o <= 1'b0;
    end else begin
      prog_valid_o <= prog_rd;
      prog_wr_refused_o <= prog_wr && !prog_wr_ok;
    end
  end
  // Reads past the store return blank
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_rdata_o <= 8'h00;
    end else if (prog_rd) begin
      prog_rdata_o <= prog_hit ? prog_mem[prog_addr_i] : 8'hFF;
    end
  end
  // ----------------------------------------
  // Stack record
  // ----------------------------------------
  // Call and return move two record bits
  cmsd_stack_record u_rec (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push1_i(push_i),
    .push2_i(call_i),
    .pop1_i(pop_i),
    .pop2_i(ret_i),
    .overflow_o(rec_ovf),
    .underflow_o(rec_unf),
    .fill_o()
  );
  // ----------------------------------------
  // Access answer
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_rdata_o <= 8'h00;
      acc_bit_rdata_o <= 1'b0;
      acc_valid_o <= 1'b0;
    end else begin
      acc_valid_o <= acc_en_i;
      if (acc_en_i) begin
        acc_rdata_o <= cur_byte;
        acc_bit_rdata_o <= cur_byte[acc_addr_i[2:0]];
      end
    end
  end
  // ----------------------------------------
  // Peripheral register request
  // ----------------------------------------
  // Local registers never reach the peripheral bus
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      per_en_o <= 1'b0;
      per_wr_o <= 1'b0;
      per_addr_o <= `CMSD_PER_BASE;
      per_wdata_o <= 8'h00;
    end else begin
      per_en_o <= acc_en_i && to_per && !local_reg;
      per_wr_o <= data_wr && to_per && !local_reg;
      per_addr_o <= eff_addr;
      per_wdata_o <= new_byte;
    end
  end
  // ----------------------------------------
  // Stack and bank status
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pop_data_o <= 8'h00;
      stack_top_pointer_o <= `CMSD_STP_RESET;
      stack_overflow_o <= 1'b0;
      stack_underflow_o <= 1'b0;
      active_bank_o <= 2'b00;
    end else begin
      // Pop reads the slot the pointer marks
      if (pop_i)
        pop_data_o <= data_ram[stack_top_pointer];
      stack_top_pointer_o <= next_stp;
      stack_overflow_o <= rec_ovf;
      stack_underflow_o <= rec_unf;
      active_bank_o <= next_bank;
    end
  end
endmodule

/* File: sim/cmsd_per_model.sv */
// Peripheral register responder behind the decoder
`timescale 1ns/100ps
module cmsd_per_model (
  input wire clk_i,
  input wire per_en_o,
  input wire per_wr_o,
  input wire [7:0] per_addr_o,
  input wire [7:0] per_wdata_o,
  output wire [7:0] per_rdata_i
);
  reg [7:0] mem [0:255];
  reg [7:0] last = 8'h00;
  integer k;
  initial for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'hA5;
  // Idle bus shows the inverse of the last value
  assign per_rdata_i = per_en_o ? mem[per_addr_o] : ~last;
  always @(posedge clk_i) begin
    if (per_en_o) last <= mem[per_addr_o];
    if (per_en_o && per_wr_o) mem[per_addr_o] <= per_wdata_o;
  end
endmodule

/* File: sim/cmsd_core_sva.sv */
// Port assertions for the memory space decoder
`timescale 1ns/100ps
module cmsd_core_sva #(
  parameter PROG_BYTES = 32896
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire acc_en_i,
  input wire acc_wr_i,
  input wire acc_bit_i,
  input wire [1:0] acc_mode_i,
  input wire [7:0] acc_addr_i,
  input wire [7:0] acc_wdata_i,
  input wire acc_valid_o,
  input wire per_en_o,
  input wire per_wr_o,
  input wire [7:0] per_addr_o,
  input wire [7:0] per_wdata_o,
  input wire push_i,
  input wire pop_i,
  input wire [7:0] stack_top_pointer_o,
  input wire prog_en_i,
  input wire prog_wr_i,
  input wire [15:0] prog_addr_i,
  input wire [7:0] prog_rdata_o,
  input wire prog_wr_refused_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_dir_per;
    acc_en_i && acc_mode_i == 2'd0 && !acc_bit_i && acc_addr_i[7] &&
      acc_addr_i != 8'h81 && acc_addr_i != 8'h8F && acc_addr_i != 8'hD0;
  endsequence
  sequence s_prog_far;
    prog_en_i && prog_addr_i >= PROG_BYTES;
  endsequence
  a_dir_per_route: assert property (s_dir_per |=>
    per_en_o && per_addr_o == $past(acc_addr_i))
    else $error("no peripheral access");
  a_per_wr_data: assert property (s_dir_per ##0 acc_wr_i |=>
    per_wr_o && per_wdata_o == $past(acc_wdata_i))
    else $error("peripheral write wrong");
  a_ind_ram_only: assert property (acc_en_i && acc_mode_i == 2'd1
    |=> !per_en_o) else $error("indirect reached peripheral");
  a_low_dir_ram: assert property (acc_en_i && acc_mode_i == 2'd0
    && !acc_addr_i[7] |=> !per_en_o) else $error("low direct left ram");
  a_acc_answer: assert property (acc_en_i |=> acc_valid_o)
    else $error("no access answer");
  a_push_step: assert property (push_i |=> stack_top_pointer_o ==
    $past(stack_top_pointer_o) + 8'h01) else $error("push pointer");
  a_pop_step: assert property (pop_i && !push_i |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01)
    else $error("pop pointer");
  a_prog_refuse: assert property (s_prog_far ##0 prog_wr_i |=>
    prog_wr_refused_o) else $error("far write taken");
  a_prog_blank: assert property (s_prog_far ##0 !prog_wr_i |=>
    prog_rdata_o == 8'hFF) else $error("far read not blank");
  a_stp_reset: assert property (disable iff (1'b0) !rst_n_i |=>
    stack_top_pointer_o == 8'h07) else $error("pointer reset");
endmodule
bind cmsd_core cmsd_core_sva #(.PROG_BYTES(PROG_BYTES)) chk_u (.*);

/* File: sim/tb_cmsd_core.sv */
// Testbench for the memory space decoder
`timescale 1ns/100ps
module tb_cmsd_core;
  reg clk_i = 0, rst_n_i = 0, acc_en_i = 0, acc_wr_i = 0, acc_bit_i = 0;
  reg acc_bit_wdata_i = 0, push_i = 0, pop_i = 0, call_i = 0, ret_i = 0;
  reg prog_en_i = 0, prog_wr_i = 0;
  reg [1:0] acc_mode_i = 0;
  reg [7:0] acc_addr_i = 0, acc_wdata_i = 0, push_data_i = 0;
  reg [7:0] prog_wdata_i = 0, rd, a, d, eo = 0, eu = 0, n_ovf = 0, n_unf = 0;
  reg [15:0] prog_addr_i = 0;
  wire [7:0] acc_rdata_o, per_addr_o, per_wdata_o, per_rdata_i, pop_data_o;
  wire [7:0] stack_top_pointer_o, prog_rdata_o;
  wire acc_bit_rdata_o, acc_valid_o, per_en_o, per_wr_o, prog_valid_o;
  wire stack_overflow_o, stack_underflow_o, prog_wr_refused_o;
  wire [1:0] active_bank_o;
  reg [7:0] ram [0:255];
  integer n_fail = 0, check_count = 0, seed = 32'h5e8d35df;
  integer i, b, stp = 7, fill = 0;
  always #5 clk_i = ~clk_i;
  cmsd_core dut_u (.*);
  cmsd_per_model per_u (.*);
  always @(posedge clk_i) begin
    if (stack_overflow_o === 1'b1) n_ovf <= n_ovf + 1;
    if (stack_underflow_o === 1'b1) n_unf <= n_unf + 1;
  end
  task chk(input [63:0] nm, input [7:0] e, input [7:0] s);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task acc(input [1:0] m, input w, input bt, input [7:0] ad, input [7:0] wd);
    begin
      @(posedge clk_i);
      acc_en_i <= 1;
      acc_mode_i <= m;
      acc_wr_i <= w;
      acc_bit_i <= bt;
      acc_addr_i <= ad;
      acc_wdata_i <= wd;
      acc_bit_wdata_i <= wd[0];
      @(posedge clk_i);
      acc_en_i <= 0;
      #1 rd = bt ? {7'h0, acc_bit_rdata_o} : acc_rdata_o;
      chk("valid", 8'h01, {7'h0, acc_valid_o});
    end
  endtask
  task stk(input up);
    begin
      d = $random(seed);
      @(posedge clk_i);
      push_i <= up;
      pop_i <= !up;
      push_data_i <= d;
      @(posedge clk_i);
      push_i <= 0;
      pop_i <= 0;
      #1;
      if (up) begin
        stp = (stp + 1) % 256;
        ram[stp] = d;
        if (fill == 32) eo = eo + 1;
        else fill = fill + 1;
      end else begin
        chk("pop", ram[stp], pop_data_o);
        stp = (stp + 255) % 256;
        if (fill == 0) eu = eu + 1;
        else fill = fill - 1;
      end
      chk("stp", stp[7:0], stack_top_pointer_o);
    end
  endtask
  task prog(input w, input [15:0] ad, input [7:0] wd, input [7:0] e);
    begin
      @(posedge clk_i);
      prog_en_i <= 1;
      prog_wr_i <= w;
      prog_addr_i <= ad;
      prog_wdata_i <= wd;
      @(posedge clk_i);
      prog_en_i <= 0;
      #1 rd = w ? {7'h0, prog_wr_refused_o} : prog_rdata_o;
      chk("prog", e, rd);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1;
    acc(0, 0, 0, 8'h81, 0);
    chk("stp", 8'h07, rd);
    for (i = 0; i < 256; i = i + 1) begin
      d = $random(seed);
      acc(1, 1, 0, i[7:0], d);
      ram[i] = d;
    end
    for (i = 0; i < 64; i = i + 1) begin
      a = $random(seed);
      acc(1, 0, 0, a, 0);
      chk("ind", ram[a], rd);
      if (!a[7]) acc(0, 0, 0, a, 0);
      if (!a[7]) chk("dir", ram[a], rd);
    end
    acc(0, 1, 0, 8'h90, 8'h5A);
    @(posedge clk_i);
    #1 chk("perwr", 8'h5A, per_u.mem[8'h90]);
    acc(1, 0, 0, 8'h90, 0);
    chk("upper", ram[8'h90], rd);
    for (b = 0; b < 4; b = b + 1) begin
      acc(0, 1, 0, 8'hD0, b << 3);
      chk("bank", b, {6'h0, active_bank_o});
      d = $random(seed);
      acc(2, 1, 0, 8'h03, d);
      ram[b * 8 + 3] = d;
      acc(1, 0, 0, b * 8 + 3, 0);
      chk("reg", d, rd);
      acc(2, 1, 0, 8'h01, 8'h30 + b);
      ram[b * 8 + 1] = 8'h30 + b;
      acc(3, 1, 0, 8'h01, d);
      ram[8'h30 + b] = d;
      acc(1, 0, 0, 8'h30 + b, 0);
      chk("ptr", d, rd);
    end
    for (i = 0; i < 16; i = i + 1) begin
      a = $random(seed) & 127;
      d = $random(seed);
      acc(0, 1, 1, a, d);
      ram[32 + a[6:3]][a[2:0]] = d[0];
      acc(1, 0, 0, 32 + a[6:3], 0);
      chk("bitbyte", ram[32 + a[6:3]], rd);
      acc(0, 0, 1, a, 0);
      chk("bit", {7'h0, d[0]}, rd);
    end
    for (i = 0; i < 33; i = i + 1) stk(1);
    for (i = 0; i < 33; i = i + 1) stk(0);
    repeat (4) @(posedge clk_i);
    chk("ovf", eo, n_ovf);
    chk("unf", eu, n_unf);
    // Seventeen calls overflow, seventeen returns underflow
    for (i = 0; i < 34; i = i + 1) begin
      @(posedge clk_i);
      call_i <= (i < 17);
      ret_i <= (i >= 17);
      @(posedge clk_i);
      call_i <= 0;
      ret_i <= 0;
    end
    repeat (4) @(posedge clk_i);
    chk("callovf", eo + 8'h01, n_ovf);
    chk("retunf", eu + 8'h01, n_unf);
    prog(1, 16'h0100, 8'hA5, 8'h01);
    acc(0, 1, 0, 8'h8F, 8'h01);
    prog(1, 16'h807F, 8'h3C, 8'h00);
    prog(0, 16'h807F, 0, 8'h3C);
    prog(1, 16'h8080, 8'h3C, 8'h01);
    prog(0, 16'h8080, 0, 8'hFF);
    test_done;
  end
endmodule
